// ===== hw/dcd_regs.svh
// Purpose: opcode and field codes of the instruction decoder
// Assumes: 32-bit instruction words, bit 31 is the most significant
// Notes: codes are given as sized hex literals
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH
`define DCD_OP_RSVD 6'h02
`define DCD_OP_LOOP 6'h03
`define DCD_OP_DO 6'h23
`define DCD_OP_CALLI 6'h04
`define DCD_OP_MOVE 6'h07
`define DCD_OP_ADD3 5'h05
`define DCD_OP_ALU 5'h06
`define DCD_TOP_BRU 3'h5
`define DCD_TOP_LDI 3'h6
`define DCD_TOP_CALLD 3'h7
`define DCD_DO_IMM 5'h00
`define DCD_DO_REG 5'h01
`define DCD_REG_PCSH 5'h1E
`define DCD_REG_RSVD_A 5'h1C
`define DCD_REG_RSVD_B 5'h1F
`define DCD_PTR_BAD 4'hF
`define DCD_M_FMT4 3'h6
`define DCD_M_RSVD 3'h7
`define DCD_FMT5_TOP 5'h0F
`endif

// ===== hw/dcd_pkg.sv
// Purpose: types shared by the decoder modules
// Assumes: codes follow declaration order where a field is cast
// Notes: none
package dcd_pkg;
  typedef enum logic [4:0] {FMT_NOP, FMT_IRET, FMT_BRC, FMT_LOOP, FMT_DOI,
    FMT_DOR, FMT_CALLI, FMT_ADD3, FMT_ALU, FMT_MOVD, FMT_MOVP, FMT_MOVIO,
    FMT_MOVMIO, FMT_BRU, FMT_LDI, FMT_CALLD, FMT_DA, FMT_ILL} fmt_type;
  typedef enum logic [3:0] {ALU_ADD, ALU_DBL, ALU_RSUB, ALU_CRADD, ALU_SUB,
    ALU_NEG, ALU_ANDN, ALU_CMP, ALU_XOR, ALU_RORC, ALU_OR, ALU_ROLC, ALU_SHR,
    ALU_HALF, ALU_AND, ALU_TST} alu_fn_type;
  typedef enum logic [3:0] {IDX_ZERO, IDX_REG, IDX_DEC, IDX_INC, DIR_ACC,
    DIR_IBUF, DIR_OBUF, DIR_PDR, DIR_NOWRITE} idx_type;
  typedef enum logic [1:0] {ROLE_X, ROLE_Y, ROLE_Z} role_type;
  typedef enum logic [1:0] {KIND_FLOAT, KIND_INT, KIND_BYTE} data_kind_type;
  typedef struct packed {
    logic n; logic z; logic v; logic c;
    logic dn; logic dz; logic dv; logic du;
    logic [7:0] io;
  } flags_type;
  typedef struct packed {
    logic direct; logic [3:0] ptr; idx_type idx; logic [2:0] idxReg;
    logic [2:0] step; logic legal;
  } opnd_type;
  typedef struct packed {
    fmt_type fmt; logic illegal; logic [4:0] cond; logic sense;
    logic [4:0] regA; logic [4:0] regB; logic [4:0] regC;
    logic [23:0] imm; logic wide; logic immSrc; alu_fn_type aluFn;
    logic aluStore; logic threeOp; logic condExec; logic store;
    logic [1:0] width; logic bitRev; logic [1:0] accSel;
  } dec_type;
endpackage : dcd_pkg

// ===== hw/dcd_opnd_dec.sv
// Purpose: decode one seven-bit pointer/index operand field
// Assumes: role tells which of the X, Y, Z slots the field is
// Notes: purely combinational
`timescale 1ns/100ps
`include "dcd_regs.svh"
module dcd_opnd_dec (
  input wire logic [6:0] field,
  input dcd_pkg::role_type role,
  input dcd_pkg::data_kind_type dataKind,
  output dcd_pkg::opnd_type opnd
);
  always_comb begin
    opnd = '0;
    opnd.ptr = field[6:3];
    opnd.idxReg = field[2:0];
    opnd.legal = 1'b1;
    opnd.step = (dataKind == dcd_pkg::KIND_FLOAT) ? 3'h4 :
                (dataKind == dcd_pkg::KIND_INT) ? 3'h2 : 3'h1;
    if (field[6:3] != 4'h0) begin
      opnd.legal = (field[6:3] != `DCD_PTR_BAD);
      case (field[2:0])
        3'h0: opnd.idx = dcd_pkg::IDX_ZERO;
        3'h6: opnd.idx = dcd_pkg::IDX_DEC;
        3'h7: opnd.idx = dcd_pkg::IDX_INC;
        default: opnd.idx = dcd_pkg::IDX_REG;
      endcase
    end else begin
      opnd.direct = 1'b1;
      case (field[2:0])
        3'h4: opnd.idx = dcd_pkg::DIR_IBUF;
        3'h5: opnd.idx = dcd_pkg::DIR_OBUF;
        3'h6: opnd.idx = dcd_pkg::DIR_PDR;
        3'h7: opnd.idx = dcd_pkg::DIR_NOWRITE;
        default: opnd.idx = dcd_pkg::DIR_ACC;
      endcase
      if (role == dcd_pkg::ROLE_Z) begin
        opnd.legal = field[2] && (field[1:0] != 2'h0);
      end else begin
        opnd.legal = !field[2] || (field[1:0] == 2'h0) ||
          (field[1:0] == 2'h2 && role == dcd_pkg::ROLE_Y);
      end
    end
  end
endmodule : dcd_opnd_dec

// ===== hw/dcd_cond_eval.sv
// Purpose: evaluate a five-bit condition code against status flags
// Assumes: flags come from logic on the same clock
// Notes: reserved codes give reserved high and holds low
`timescale 1ns/100ps
module dcd_cond_eval (
  input wire logic [4:0] cond,
  input dcd_pkg::flags_type flags,
  output logic holds,
  output logic reserved
);
  always_comb begin
    holds = 1'b0;
    reserved = 1'b0;
    case (cond[4:3])
      2'h0: begin
        case (cond[2:0])
          3'h0: holds = 1'b1;
          3'h1: holds = flags.n;
          3'h2: holds = flags.z;
          3'h3: holds = flags.v;
          3'h4: holds = flags.c;
          3'h5: holds = flags.n ^ flags.v;
          3'h6: holds = flags.z | (flags.n ^ flags.v);
          default: holds = flags.c | flags.z;
        endcase
      end
      2'h1: begin
        case (cond[2:0])
          3'h0: holds = flags.du;
          3'h1: holds = flags.dn;
          3'h2: holds = flags.dz;
          3'h3: holds = flags.dv;
          3'h4: holds = flags.dn | flags.dz;
          default: reserved = 1'b1;
        endcase
      end
      2'h2: holds = flags.io[cond[2:0]];
      default: reserved = 1'b1;
    endcase
  end
endmodule : dcd_cond_eval

// ===== hw/dcd_decoder.sv
// Purpose: decode instruction words into control for registers,
//   ALU, memory moves and branches
// Assumes: word and flags come from sequencer logic on mclk
// Notes: outputs appear one clock after instrValid
`timescale 1ns/100ps
`include "dcd_regs.svh"
module dcd_decoder (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input dcd_pkg::data_kind_type dataKind,
  input dcd_pkg::flags_type flags,
  output logic decValid,
  output dcd_pkg::dec_type decoded,
  output dcd_pkg::opnd_type [2:0] operands,
  output logic branchTaken
);
  logic [1:0] rstSync_ff;
  logic rstN;
  logic decValid_ff;
  dcd_pkg::dec_type dec_ff;
  dcd_pkg::dec_type nxt_dec;
  dcd_pkg::opnd_type [2:0] opnd_ff;
  dcd_pkg::opnd_type [2:0] nxt_opnd;
  logic branchTaken_ff;
  logic nxt_taken;
  logic [4:0] condSel;
  logic condHolds;
  logic condRsvd;
  logic [31:0] w;

  default clocking dflt_cb @(posedge mclk);
  endclocking
  default disable iff (!rstN);

  // register codes that name a defined register
  function automatic logic regOk(input logic [4:0] r);
    regOk = (r != `DCD_REG_RSVD_A) && (r != `DCD_REG_RSVD_B);
  endfunction : regOk

  // pointer codes usable by a register-indirect move
  function automatic logic ptrOk(input logic [4:0] r);
    case (r)
      5'h00, 5'h0F, 5'h10, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1E,
      5'h1F: ptrOk = 1'b0;
      default: ptrOk = 1'b1;
    endcase
  endfunction : ptrOk

  // index codes usable by a register-indirect move
  function automatic logic idxOk(input logic [4:0] r);
    case (r)
      5'h00, 5'h0F, 5'h1A, 5'h1B, 5'h1C, 5'h1E, 5'h1F: idxOk = 1'b0;
      default: idxOk = 1'b1;
    endcase
  endfunction : idxOk

  // I/O register codes that name a register
  function automatic logic ioOk(input logic [4:0] r);
    case (r)
      5'h04, 5'h05, 5'h06, 5'h0E, 5'h14, 5'h16, 5'h1E: ioOk = 1'b1;
      default: ioOk = 1'b0;
    endcase
  endfunction : ioOk

  assign w = instrWord;
  assign rstN = rstSync_ff[1];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end

  // branches use the full code, register-source ALU the low three bits
  assign condSel = (w[30:26] == `DCD_OP_ALU) ? {2'h0, w[15:13]} :
                   w[26:22];

  dcd_cond_eval u_cond (
    .cond(condSel),
    .flags(flags),
    .holds(condHolds),
    .reserved(condRsvd)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_opnd
      dcd_opnd_dec u_opnd (
        .field(w[20-7*g -: 7]),
        .role(dcd_pkg::role_type'(g)),
        .dataKind(dataKind),
        .opnd(nxt_opnd[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_dec = '0;
    nxt_dec.fmt = dcd_pkg::FMT_ILL;
    nxt_dec.regA = w[20:16];
    nxt_dec.imm = {{8{w[15]}}, w[15:0]};
    nxt_taken = 1'b0;
    if (w[31:29] == `DCD_TOP_BRU || w[31:29] == `DCD_TOP_LDI ||
        w[31:29] == `DCD_TOP_CALLD) begin
      nxt_dec.imm = {w[28:21], w[15:0]};
      nxt_dec.wide = 1'b1;
      case (w[31:29])
        `DCD_TOP_BRU: nxt_dec.fmt = dcd_pkg::FMT_BRU;
        `DCD_TOP_LDI: nxt_dec.fmt = dcd_pkg::FMT_LDI;
        default: nxt_dec.fmt = dcd_pkg::FMT_CALLD;
      endcase
      nxt_taken = (w[31:29] != `DCD_TOP_LDI);
    end else if (w[31:27] == 5'h00) begin
      nxt_dec.cond = w[26:22];
      nxt_dec.sense = w[21];
      nxt_dec.fmt = dcd_pkg::FMT_BRC;
      if (w[26:0] == {5'h00, 1'b1, `DCD_REG_PCSH, 16'h0000}) begin
        nxt_dec.fmt = dcd_pkg::FMT_IRET;
      end else if (w[26:0] == 27'h0) begin
        nxt_dec.fmt = dcd_pkg::FMT_NOP;
      end
      nxt_taken = (condHolds == w[21]) && !condRsvd;
      if (condRsvd || !regOk(w[20:16])) begin
        nxt_dec.fmt = dcd_pkg::FMT_ILL;
        nxt_taken = 1'b0;
      end
    end else if (w[30:26] == `DCD_OP_ADD3) begin
      nxt_dec.fmt = dcd_pkg::FMT_ADD3;
      nxt_dec.wide = w[31];
      nxt_dec.regA = w[25:21];
      nxt_dec.regB = w[20:16];
      if (!w[31]) begin
        nxt_dec.imm = {8'h00, w[15:0]};
      end
      if (!regOk(w[25:21]) || !regOk(w[20:16])) begin
        nxt_dec.fmt = dcd_pkg::FMT_ILL;
      end
    end else if (w[30:26] == `DCD_OP_ALU) begin
      nxt_dec.fmt = dcd_pkg::FMT_ALU;
      nxt_dec.wide = w[31];
      nxt_dec.immSrc = w[25];
      nxt_dec.aluFn = dcd_pkg::alu_fn_type'(w[24:21]);
      nxt_dec.aluStore = (w[24:21] != 4'h7) && (w[24:21] != 4'hF);
      nxt_dec.regA = w[20:16];
      if (!w[31]) begin
        nxt_dec.imm = {8'h00, w[15:0]};
      end
      if (!w[25]) begin
        nxt_dec.cond = {2'h0, w[15:13]};
        nxt_dec.condExec = w[10];
        nxt_dec.threeOp = w[11];
        nxt_dec.sense = w[12];
        nxt_dec.regB = w[9:5];
        nxt_dec.regC = w[4:0];
        nxt_dec.imm = 24'h0;
        nxt_taken = !w[10] || condHolds;
      end else begin
        nxt_taken = 1'b1;
      end
      if (!regOk(w[20:16]) ||
          (!w[25] && (!regOk(w[9:5]) || !regOk(w[4:0])))) begin
        nxt_dec.fmt = dcd_pkg::FMT_ILL;
        nxt_taken = 1'b0;
      end
    end else if (w[31:26] == `DCD_OP_LOOP) begin
      nxt_dec.fmt = dcd_pkg::FMT_LOOP;
      nxt_dec.regB = w[25:21];
      nxt_dec.imm = {8'h00, w[15:0]};
      if (!regOk(w[25:21]) || !regOk(w[20:16])) begin
        nxt_dec.fmt = dcd_pkg::FMT_ILL;
      end
    end else if (w[31:26] == `DCD_OP_DO) begin
      nxt_dec.regB = w[4:0];
      if (w[25:21] == `DCD_DO_IMM && w[15:11] == 5'h00) begin
        nxt_dec.fmt = dcd_pkg::FMT_DOI;
        nxt_dec.imm = {13'h0, w[10:0]};
      end else if (w[25:21] == `DCD_DO_REG && w[15:5] == 11'h000 &&
                   regOk(w[4:0])) begin
        nxt_dec.fmt = dcd_pkg::FMT_DOR;
        nxt_dec.imm = 24'h0;
      end
    end else if (w[31:26] == `DCD_OP_CALLI) begin
      nxt_dec.fmt = dcd_pkg::FMT_CALLI;
      nxt_dec.regB = w[25:21];
      nxt_taken = 1'b1;
      if (!regOk(w[25:21]) || !regOk(w[20:16])) begin
        nxt_dec.fmt = dcd_pkg::FMT_ILL;
        nxt_taken = 1'b0;
      end
    end else if (w[31:26] == `DCD_OP_MOVE) begin
      nxt_dec.store = w[24];
      nxt_dec.width = w[23:22];
      nxt_dec.bitRev = w[10];
      nxt_dec.regB = w[9:5];
      nxt_dec.regC = w[4:0];
      case ({w[25], w[21]})
        2'b00: begin
          nxt_dec.fmt = dcd_pkg::FMT_MOVD;
          nxt_dec.imm = {8'h00, w[15:0]};
          nxt_dec.bitRev = 1'b0;
          if (!regOk(w[20:16])) begin
            nxt_dec.fmt = dcd_pkg::FMT_ILL;
          end
        end
        2'b11: begin
          nxt_dec.fmt = dcd_pkg::FMT_MOVP;
          nxt_dec.imm = 24'h0;
          if (!ptrOk(w[9:5]) || !idxOk(w[4:0]) || !regOk(w[20:16])) begin
            nxt_dec.fmt = dcd_pkg::FMT_ILL;
          end
        end
        2'b10: begin
          nxt_dec.fmt = dcd_pkg::FMT_MOVIO;
          nxt_dec.imm = 24'h0;
          nxt_dec.bitRev = 1'b0;
          if (w[9:5] != 5'h00 || !ioOk(w[4:0]) || !regOk(w[20:16])) begin
            nxt_dec.fmt = dcd_pkg::FMT_ILL;
          end
        end
        default: begin
          nxt_dec.fmt = dcd_pkg::FMT_MOVMIO;
          nxt_dec.imm = 24'h0;
          if (!ioOk(w[20:16]) || !ptrOk(w[9:5]) || !idxOk(w[4:0])) begin
            nxt_dec.fmt = dcd_pkg::FMT_ILL;
          end
        end
      endcase
    end else if (w[31:29] != 3'h0 && !w[31]) begin
      // data-arithmetic word: operand fields and accumulator selector
      nxt_dec.fmt = dcd_pkg::FMT_DA;
      nxt_dec.bitRev = w[25];
      nxt_dec.accSel = w[27:26];
      nxt_dec.imm = 24'h0;
      if (!nxt_opnd[0].legal || !nxt_opnd[1].legal ||
          !nxt_opnd[2].legal || w[28:26] == `DCD_M_RSVD ||
          (w[28:26] == `DCD_M_FMT4 && w[31:29] != 3'h1) ||
          (w[31:27] == `DCD_FMT5_TOP &&
           (w[26:23] == 4'h8 || w[26:23] == 4'h9 || w[26:23] == 4'hF))) begin
        nxt_dec.fmt = dcd_pkg::FMT_ILL;
      end
    end
    nxt_dec.illegal = (nxt_dec.fmt == dcd_pkg::FMT_ILL);
    if (nxt_dec.illegal) begin
      nxt_dec.aluStore = 1'b0;
      nxt_dec.store = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      decValid_ff <= 1'b0;
    end else begin
      decValid_ff <= instrValid;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dec_ff <= '0;
      opnd_ff <= '0;
      branchTaken_ff <= 1'b0;
    end else if (instrValid) begin
      dec_ff <= nxt_dec;
      opnd_ff <= nxt_opnd;
      branchTaken_ff <= nxt_taken;
    end
  end

  assign decValid = decValid_ff;
  assign decoded = dec_ff;
  assign operands = opnd_ff;
  assign branchTaken = branchTaken_ff;

  acc_select_a: assert property (
    instrValid && w[31:29] == 3'h1 && !w[28] |=>
    decoded.accSel == $past(w[27:26]) &&
    (decoded.fmt == dcd_pkg::FMT_DA || decoded.illegal))
    else $error("accumulator selector wrong");
  index_zero_a: assert property (
    instrValid && w[6:3] != 4'h0 && w[2:0] == 3'h0 |=>
    operands[2].idx == dcd_pkg::IDX_ZERO && !operands[2].direct)
    else $error("zero index not decoded");
  z_direct_a: assert property (
    instrValid && w[31:29] == 3'h1 && w[6:2] == 5'h00 |=> decoded.illegal)
    else $error("accumulator as Z accepted");
  branch_fields_a: assert property (
    instrValid && w[31:27] == 5'h00 && !decoded.illegal |=> decoded.illegal ||
    (decoded.cond == $past(w[26:22]) && decoded.sense == $past(w[21])))
    else $error("branch fields wrong");
  nop_word_a: assert property (
    instrValid && w == 32'h0000_0000 |=>
    decoded.fmt == dcd_pkg::FMT_NOP && !branchTaken)
    else $error("nop misdecoded");
  do_count_a: assert property (
    decoded.fmt == dcd_pkg::FMT_DOI |-> decoded.imm[23:11] == 13'h0000)
    else $error("do count too wide");
  sext_add_a: assert property (
    instrValid && w[31:26] == 6'h25 && w[15] && w[25:21] == 5'h01 &&
    w[20:16] == 5'h02 |=> decoded.imm[23:16] == 8'hFF && decoded.wide)
    else $error("24-bit add not sign extended");
  imm_join_a: assert property (
    instrValid && w[31:29] == `DCD_TOP_LDI |=>
    decoded.imm == {$past(w[28:21]), $past(w[15:0])})
    else $error("immediate join wrong");
  taken_sense_a: assert property (
    decoded.fmt == dcd_pkg::FMT_BRC && decoded.cond == 5'h00 |->
    branchTaken == decoded.sense)
    else $error("branch sense ignored");
  rsvd_fmt_a: assert property (
    instrValid && w[31:26] == `DCD_OP_RSVD |=>
    decoded.illegal && !decoded.store && !decoded.aluStore)
    else $error("reserved format accepted");
  iret_c: cover property (@(posedge mclk) disable iff (!rstN)
    decValid && decoded.fmt == dcd_pkg::FMT_IRET);
  alu_cond_c: cover property (@(posedge mclk) disable iff (!rstN)
    decValid && decoded.fmt == dcd_pkg::FMT_ALU && decoded.condExec);
  move_ptr_c: cover property (@(posedge mclk) disable iff (!rstN)
    decValid && decoded.fmt == dcd_pkg::FMT_MOVP && decoded.bitRev);
  taken_brc_c: cover property (@(posedge mclk) disable iff (!rstN)
    decValid && decoded.fmt == dcd_pkg::FMT_BRC && branchTaken);
  illegal_c: cover property (@(posedge mclk) disable iff (!rstN)
    decValid && decoded.illegal);
  illegal_quiet_a: assert property (
    decoded.illegal |-> !decoded.store && !decoded.aluStore && !branchTaken)
    else $error("illegal word has side effects");
  alu_exec_a: assert property (
    instrValid && w[30:26] == `DCD_OP_ALU && !w[25] && !w[10] &&
    regOk(w[20:16]) && regOk(w[9:5]) && regOk(w[4:0]) |=> branchTaken)
    else $error("unconditional ALU word not executed");
  move_dir_a: assert property (
    instrValid && w[31:26] == `DCD_OP_MOVE |=>
    decoded.illegal || decoded.store == $past(w[24]))
    else $error("move direction wrong");
  move_width_a: assert property (
    instrValid && w[31:26] == `DCD_OP_MOVE |=>
    decoded.width == $past(w[23:22]))
    else $error("move width wrong");
  step_size_a: assert property (
    instrValid && dataKind == dcd_pkg::KIND_BYTE |=>
    operands[0].step == 3'h1)
    else $error("byte step wrong");
endmodule : dcd_decoder

// ===== testbench/dcd_seq_model.sv
// Purpose: sequencer model that hands instruction words to the decoder
// Assumes: words and flags change just after the falling edge of mclk
// Notes: while idle the word lines show the inverse of the last word
`timescale 1ns/100ps
module dcd_seq_model (
  input wire logic mclk,
  output logic instrValid,
  output logic [31:0] instrWord,
  output dcd_pkg::flags_type flags,
  output dcd_pkg::data_kind_type dataKind
);
  initial begin
    instrValid = 1'b0;
    instrWord = 32'h0;
    flags = '0;
    dataKind = dcd_pkg::KIND_FLOAT;
  end
  // one word per call; back-to-back calls fill every cycle
  task automatic drive(input logic [31:0] w, input dcd_pkg::flags_type f,
      input dcd_pkg::data_kind_type k);
    @(negedge mclk);
    instrValid <= 1'b1;
    instrWord <= w;
    flags <= f;
    dataKind <= k;
  endtask : drive
  task automatic idle;
    @(negedge mclk);
    instrValid <= 1'b0;
    instrWord <= ~instrWord;
  endtask : idle
endmodule : dcd_seq_model

// ===== testbench/testbench.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: one expectation is queued for every word sent
// Notes: a monitor pops the oldest expectation at each decValid
`timescale 1ns/100ps
module testbench;
  typedef struct {
    dcd_pkg::fmt_type fmt; logic bt; int sel; logic [31:0] val;
  } dcd_exp_type;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic instrValid;
  logic decValid;
  logic branchTaken;
  logic [31:0] instrWord;
  dcd_pkg::data_kind_type dataKind;
  dcd_pkg::flags_type flags;
  dcd_pkg::dec_type decoded;
  dcd_pkg::opnd_type [2:0] operands;
  dcd_pkg::flags_type fl = '0;
  dcd_pkg::data_kind_type dk = dcd_pkg::KIND_FLOAT;
  dcd_exp_type expQ[$];
  int failures = 0;
  int samples_checked = 0;
  int seed = 25307;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  dcd_decoder uut (.mclk(mclk), .reset_n(reset_n), .instrValid(instrValid),
    .instrWord(instrWord), .dataKind(dataKind), .flags(flags),
    .decValid(decValid), .decoded(decoded), .operands(operands),
    .branchTaken(branchTaken));
  dcd_seq_model seq (.mclk(mclk), .instrValid(instrValid),
    .instrWord(instrWord), .flags(flags), .dataKind(dataKind));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_fmt(input dcd_pkg::fmt_type got,
      input dcd_pkg::fmt_type exp);
    chk_val({27'h0, got}, {27'h0, exp});
  endtask : chk_fmt
  function automatic logic ca(input logic [4:0] c,
      input dcd_pkg::flags_type f);
    case (c)
      5'h00: return 1'b1;
      5'h01: return f.n;
      5'h02: return f.z;
      5'h03: return f.v;
      5'h04: return f.c;
      5'h05: return f.n ^ f.v;
      5'h06: return f.z | (f.n ^ f.v);
      5'h07: return f.c | f.z;
      default: return f.io[c[2:0]];
    endcase
  endfunction : ca
  function automatic logic [31:0] pick(input int s);
    case (s)
      1: return {8'h0, decoded.imm};
      2: return {27'h0, decoded.regA};
      3: return {27'h0, decoded.aluFn, decoded.aluStore};
      4: return {28'h0, decoded.store, decoded.width, decoded.bitRev};
      5: return {15'h0, decoded.accSel, operands[0].idx, operands[1].idx,
        operands[2].idx, operands[0].step};
      6: return {20'h0, decoded.threeOp, decoded.condExec, decoded.regB,
        decoded.regC};
      default: return 32'h0;
    endcase
  endfunction : pick
  task automatic go(input logic [31:0] w, input dcd_pkg::fmt_type fm,
      input logic bt, input int sel, input logic [31:0] val);
    expQ.push_back('{fm, bt, sel, val});
    seq.drive(w, fl, dk);
  endtask : go
  always @(posedge mclk) begin : mon
    dcd_exp_type e;
    #1;
    if (decValid === 1'b1) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("mismatch at %0t got %0h exp %0h", $time, 1, 0);
      end else begin
        e = expQ.pop_front();
        chk_fmt(decoded.fmt, e.fmt);
        chk_val({31'h0, branchTaken}, {31'h0, e.bt});
        chk_val({31'h0, decoded.illegal},
          {31'h0, e.fmt == dcd_pkg::FMT_ILL});
        chk_val(pick(e.sel), e.val);
      end
    end
  end
  initial begin
    #(25ns * 4000);
    failures++;
    $display("watchdog expired before the tests ended");
    test_done();
  end
  initial begin : main
    logic [15:0] n;
    logic [4:0] h;
    logic [31:0] w;
    logic s;
    logic g;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    n = 16'($random(seed));
    h = {2'h0, 3'($random(seed))} + 5'h01;
    go(32'h0, dcd_pkg::FMT_NOP, 0, 0, 0);
    go(32'h003E0000, dcd_pkg::FMT_IRET, 1, 0, 0);
    go(32'h08000000, dcd_pkg::FMT_ILL, 0, 0, 0);
    go({6'h03, 5'h01, 5'h1C, n}, dcd_pkg::FMT_ILL, 0, 0, 0);
    for (int c = 1; c < 24; c++) begin
      if (c > 7 && c < 16) continue;
      fl = 16'($random(seed));
      s = 1'($random(seed));
      go({5'h0, 5'(c), s, h, n}, dcd_pkg::FMT_BRC, ca(5'(c), fl) == s, 1,
        {8'h0, {8{n[15]}}, n});
    end
    go({6'h03, h, h, n}, dcd_pkg::FMT_LOOP, 0, 2, h);
    go({6'h23, 5'h00, h, 5'h00, n[10:0]}, dcd_pkg::FMT_DOI, 0, 1,
      {21'h0, n[10:0]});
    go({6'h23, 5'h01, h, 11'h0, h}, dcd_pkg::FMT_DOR, 0, 2, h);
    go({6'h04, h, h, n}, dcd_pkg::FMT_CALLI, 1, 1,
      {8'h0, {8{n[15]}}, n});
    go({6'h05, h, h, n}, dcd_pkg::FMT_ADD3, 0, 1, {16'h0, n});
    go({6'h25, h, h, n}, dcd_pkg::FMT_ADD3, 0, 1,
      {8'h0, {8{n[15]}}, n});
    for (int t = 5; t < 8; t++) begin
      go({3'(t), n[7:0], h, n}, dcd_pkg::fmt_type'(5'(t + 8)), t != 6, 1,
        {8'h0, n[7:0], n});
    end
    for (int f = 0; f < 16; f++) begin
      go({1'b0, 5'h06, 1'b1, 4'(f), h, n}, dcd_pkg::FMT_ALU, 1, 3,
        {4'(f), f != 7 && f != 15});
    end
    for (int c = 0; c < 8; c++) begin
      fl = 16'($random(seed));
      s = 1'($random(seed));
      g = 1'($random(seed));
      go({6'h06, 5'h00, h, 3'(c), 1'b0, s, g, h, h}, dcd_pkg::FMT_ALU,
        !g || ca(5'(c), fl), 6,
        {s, g, h, h});
    end
    for (int i = 0; i < 16; i++) begin
      w = {6'h07, 1'b1, 1'(i >> 3), 2'(i >> 1), 1'b1, h, 5'h00, 1'(i),
        5'h01, 5'h01};
      go(w, dcd_pkg::FMT_MOVP, 0, 4,
        i);
    end
    go({6'h07, 4'h3, 1'b0, h, n}, dcd_pkg::FMT_MOVD, 0, 2, h);
    go({6'h07, 4'hB, 1'b0, h, 11'h0, 5'h04}, dcd_pkg::FMT_MOVIO, 0, 2,
      h);
    go({6'h07, 4'hB, 1'b0, h, 6'h0, 5'h01, 5'h04}, dcd_pkg::FMT_ILL, 0, 0,
      0);
    go({6'h07, 4'h3, 1'b1, 5'h04, 6'h0, 5'h01, 5'h01}, dcd_pkg::FMT_MOVMIO,
      0, 2, 5'h04);
    for (int i = 0; i < 12; i++) begin
      dk = dcd_pkg::data_kind_type'(2'(i % 3));
      go({4'h2, 2'(i / 3), 5'h02, 7'h0E, 7'h04, 7'h07}, dcd_pkg::FMT_DA, 0, 5,
        {2'(i / 3), 4'(dcd_pkg::IDX_DEC), 4'(dcd_pkg::DIR_IBUF),
        4'(dcd_pkg::DIR_NOWRITE), 3'(4 >> (i % 3))});
    end
    go({4'h2, 2'h0, 5'h02, 7'h0E, 7'h04, 7'h08}, dcd_pkg::FMT_DA, 0, 5,
      {2'h0, 4'(dcd_pkg::IDX_DEC), 4'(dcd_pkg::DIR_IBUF),
      4'(dcd_pkg::IDX_ZERO), 3'h1});
    go({4'h2, 2'h3, 5'h02, 7'h0C, 7'h06, 7'h05}, dcd_pkg::FMT_DA, 0, 5,
      {2'h3, 4'(dcd_pkg::IDX_REG), 4'(dcd_pkg::DIR_PDR),
      4'(dcd_pkg::DIR_OBUF), 3'h1});
    go({4'h2, 2'h1, 5'h02, 7'h0E, 7'h04, 7'h01}, dcd_pkg::FMT_ILL, 0, 0,
      0);
    go({4'h2, 2'h2, 5'h02, 7'h06, 7'h06, 7'h05}, dcd_pkg::FMT_ILL, 0, 0,
      0);
    seq.idle();
    repeat (4) @(posedge mclk);
    chk_val(expQ.size(), 0);
    test_done();
  end
endmodule : testbench
